// ==== sbrg_pkg.sv ====
package sbrg_pkg;
    // Register word indices within a bank
    localparam logic [7:0] REG_RXCTL_IDX   = 8'h13;
    localparam logic [7:0] REG_TXCTL_IDX   = 8'h15;
    localparam logic [7:0] REG_DIV_IDX     = 8'h17;
    // Bank numbers of the two ports
    localparam logic [3:0] BANK_PORT1      = 4'h0;
    localparam logic [3:0] BANK_PORT2      = 4'h4;
    // Field positions and reset values
    localparam int         SYNC_BIT        = 4;
    localparam logic [7:0] DIV_RESET       = 8'h00;
    localparam logic [7:0] TXCTL_RESET     = 8'h02;
    localparam logic [7:0] TXCTL_WMASK     = 8'hF1;
    localparam logic [7:0] RXCTL_RESET     = 8'h00;
    localparam logic [7:0] RXCTL_WMASK     = 8'hF1;
    // Prescale applied after the rate timer tick
    localparam logic [5:0] PRESCALE_ASYNC  = 6'h3F;
    localparam logic [5:0] PRESCALE_SYNC   = 6'h03;
    localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

    // Bus request carrier
    typedef struct packed {
        logic        read;
        logic        write;
        logic [11:0] address;
        logic [31:0] writedata;
    } sbrg_req_s;

    // Per-port rate outputs
    typedef struct packed {
        logic tick;
        logic bit_clk;
    } sbrg_rate_s;
endpackage

// ==== sbrg_timer.sv ====
`timescale 1ns/1ns
// One rate generator: 8-bit reload timer followed by mode prescale
module sbrg_timer
    import sbrg_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk_in,   // System clock
    input  wire logic             resetn_in,    // Async reset, low
    input  wire logic [WIDTH-1:0] divider_in,   // Divider value X
    input  wire logic             restart_in,   // Divider was written
    input  wire logic             sync_in,      // Mode select
    output sbrg_rate_s            rate_out      // Tick and bit pulse
);
    // Widths outside 1 to 16 are refused at elaboration
    if (WIDTH < 1 || WIDTH > 16) begin
        $error("sbrg_timer WIDTH out of range");
    end

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic [5:0]       pre;
        logic             tick;
        logic             bit_clk;
    } sbrg_tstate_s;

    sbrg_tstate_s state_ff;
    sbrg_tstate_s nxt_state;
    logic [5:0]   pre_limit;

    ////////////////////////////////////////////////////////////////////
    // Next state; a restart wins over counting
    always_comb begin
        nxt_state = state_ff;
        nxt_state.tick = 1'b0;
        nxt_state.bit_clk = 1'b0;
        pre_limit = sync_in ? PRESCALE_SYNC : PRESCALE_ASYNC;
        if (restart_in) begin
            nxt_state.count = divider_in;
            nxt_state.pre = '0;
        end else if (state_ff.count == '0) begin
            nxt_state.count = divider_in;
            nxt_state.tick = 1'b1;
            if (state_ff.pre >= pre_limit) begin
                nxt_state.pre = '0;
                nxt_state.bit_clk = 1'b1;
            end else begin
                nxt_state.pre = state_ff.pre + 6'h01;
            end
        end else begin
            nxt_state.count = state_ff.count - WIDTH'(1);
        end
    end

    // State register
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rate_out.tick    = state_ff.tick;
    assign rate_out.bit_clk = state_ff.bit_clk;

    // A restart loads X and clears the prescale, with no tick
    AST_RESTART_TICK: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        restart_in |=> (!state_ff.tick && state_ff.pre == '0
            && state_ff.count == $past(divider_in)))
        else $error("restart did not reload the timer");
    // Reset in the antecedent keeps the release edge from starting it
    AST_RELOAD: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (resetn_in && state_ff.count == '0 && !restart_in) |=>
            (state_ff.tick && state_ff.count == $past(divider_in)))
        else $error("timer did not reload");
    AST_BIT_HAS_TICK: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        state_ff.bit_clk |-> state_ff.tick)
        else $error("bit pulse without tick");
endmodule

// ==== sbrg_top.sv ====
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ns
// How it works
// - Synchronous mode: bit rate is clock over 4 times (X+1).
// - Writing the divider restarts its timer one cycle after the write.
// - Any reset clears both dividers to zero.
// - Two generators, divider at index 17h in banks 0 and 4.
// - Asynchronous mode: bit rate is clock over 64 times (X+1).
// - Each generator is a free-running 8-bit timer.
module sbrg_top
    import sbrg_pkg::*;
(
    input  wire logic        sys_clk_in,         // 250 MHz clock
    input  wire logic        resetn_in,          // Async reset, low
    input  wire logic [11:0] avs_address_in,     // Byte address
    input  wire logic        avs_read_in,        // Read strobe
    input  wire logic        avs_write_in,       // Write strobe
    input  wire logic [3:0]  avs_byteenable_in,  // Byte lanes
    input  wire logic [31:0] avs_writedata_in,   // Write data
    output logic [31:0]      avs_readdata_out,   // Read data
    output logic             avs_waitrequest_out,// Stall
    output sbrg_rate_s       rate_port1_out,     // Port 1 rate
    output sbrg_rate_s       rate_port2_out      // Port 2 rate
);
    typedef struct packed {
        logic [7:0]  div1;
        logic [7:0]  div2;
        logic [7:0]  tx1;
        logic [7:0]  tx2;
        logic [7:0]  rc1;
        logic [7:0]  rc2;
        logic        restart1;
        logic        restart2;
        logic        ack;
        logic [31:0] rdata;
    } sbrg_state_s;

    sbrg_state_s state_ff;
    sbrg_state_s nxt_state;
    sbrg_req_s   req;

    assign req.read      = avs_read_in;
    assign req.write     = avs_write_in;
    assign req.address   = avs_address_in;
    assign req.writedata = avs_writedata_in;

    // Address = {bank, index} words; byte address = 4 * word index
    function automatic logic hit(input logic [11:0] addr,
                                 input logic [3:0] bank,
                                 input logic [7:0] idx);
        hit = (addr[1:0] == 2'b00) && (addr[11:2] == {bank, idx[5:0]})
              && (idx[7:6] == 2'b00);
    endfunction

    // Byte lane 0 merge with write mask
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] wd,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (wd & mask);
    endfunction

    logic wr_en;
    logic rd_en;

    ////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, answer on the second edge
    always_comb begin
        nxt_state = state_ff;
        nxt_state.restart1 = 1'b0;
        nxt_state.restart2 = 1'b0;
        nxt_state.ack = 1'b0;
        wr_en = req.write && !state_ff.ack && avs_byteenable_in[0];
        rd_en = req.read && !state_ff.ack;
        if (req.read || req.write) begin
            nxt_state.ack = !state_ff.ack;
        end
        if (wr_en) begin
            if (hit(req.address, BANK_PORT1, REG_DIV_IDX)) begin
                nxt_state.div1 = req.writedata[7:0];
                nxt_state.restart1 = 1'b1;
            end
            if (hit(req.address, BANK_PORT2, REG_DIV_IDX)) begin
                nxt_state.div2 = req.writedata[7:0];
                nxt_state.restart2 = 1'b1;
            end
            if (hit(req.address, BANK_PORT1, REG_TXCTL_IDX)) begin
                nxt_state.tx1 = merge(state_ff.tx1, req.writedata[7:0],
                                      TXCTL_WMASK);
            end
            if (hit(req.address, BANK_PORT2, REG_TXCTL_IDX)) begin
                nxt_state.tx2 = merge(state_ff.tx2, req.writedata[7:0],
                                      TXCTL_WMASK);
            end
            if (hit(req.address, BANK_PORT1, REG_RXCTL_IDX)) begin
                nxt_state.rc1 = merge(state_ff.rc1, req.writedata[7:0],
                                      RXCTL_WMASK);
            end
            if (hit(req.address, BANK_PORT2, REG_RXCTL_IDX)) begin
                nxt_state.rc2 = merge(state_ff.rc2, req.writedata[7:0],
                                      RXCTL_WMASK);
            end
        end
        if (rd_en) begin
            nxt_state.rdata = UNMAPPED_DATA;
            if (hit(req.address, BANK_PORT1, REG_DIV_IDX)) begin
                nxt_state.rdata = {24'h000000, state_ff.div1};
            end else if (hit(req.address, BANK_PORT2, REG_DIV_IDX)) begin
                nxt_state.rdata = {24'h000000, state_ff.div2};
            end else if (hit(req.address, BANK_PORT1, REG_TXCTL_IDX)) begin
                nxt_state.rdata = {24'h000000, state_ff.tx1};
            end else if (hit(req.address, BANK_PORT2, REG_TXCTL_IDX)) begin
                nxt_state.rdata = {24'h000000, state_ff.tx2};
            end else if (hit(req.address, BANK_PORT1, REG_RXCTL_IDX)) begin
                nxt_state.rdata = {24'h000000, state_ff.rc1};
            end else if (hit(req.address, BANK_PORT2, REG_RXCTL_IDX)) begin
                nxt_state.rdata = {24'h000000, state_ff.rc2};
            end
        end
    end

    // State register; every reset source arrives on resetn_in
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff.div1     <= DIV_RESET;
            state_ff.div2     <= DIV_RESET;
            state_ff.tx1      <= TXCTL_RESET;
            state_ff.tx2      <= TXCTL_RESET;
            state_ff.rc1      <= RXCTL_RESET;
            state_ff.rc2      <= RXCTL_RESET;
            state_ff.restart1 <= 1'b0;
            state_ff.restart2 <= 1'b0;
            state_ff.ack      <= 1'b0;
            state_ff.rdata    <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Waitrequest low only in the answer cycle
    assign avs_waitrequest_out = !state_ff.ack;
    assign avs_readdata_out    = state_ff.rdata;

    ////////////////////////////////////////////////////////////////////
    // Generator instances; the restart pulse follows the write by one
    // cycle, so the new rate starts from a full period
    sbrg_timer #(.WIDTH(8)) u_port1 (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .divider_in (state_ff.div1),
        .restart_in (state_ff.restart1),
        .sync_in    (state_ff.tx1[SYNC_BIT]),
        .rate_out   (rate_port1_out)
    );
    sbrg_timer #(.WIDTH(8)) u_port2 (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .divider_in (state_ff.div2),
        .restart_in (state_ff.restart2),
        .sync_in    (state_ff.tx2[SYNC_BIT]),
        .rate_out   (rate_port2_out)
    );

    ////////////////////////////////////////////////////////////////////
    // Every divider write with byte lane 0 enabled lands and restarts only its own timer
    AST_DIV_WRITE: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (wr_en && hit(req.address, BANK_PORT1, REG_DIV_IDX)) |=>
            (state_ff.restart1
             && state_ff.div1 == $past(req.writedata[7:0])))
        else $error("divider write lost");
    AST_DIV2_WRITE: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (wr_en && hit(req.address, BANK_PORT2, REG_DIV_IDX)) |=>
            (state_ff.restart2
             && state_ff.div2 == $past(req.writedata[7:0])))
        else $error("second divider write lost");
    // The port 1 mode bit follows a transmit control write
    AST_MODE_WRITE: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (wr_en && hit(req.address, BANK_PORT1, REG_TXCTL_IDX)) |=>
            (state_ff.tx1[SYNC_BIT] == $past(req.writedata[SYNC_BIT])))
        else $error("mode bit write lost");
    AST_ISOLATED: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        state_ff.restart2 |-> !state_ff.restart1)
        else $error("ports not independent");
    AST_SYNC_RESET: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        $rose(resetn_in) |-> (state_ff.div1 == DIV_RESET
            && state_ff.div2 == DIV_RESET
            && !state_ff.tx1[SYNC_BIT] && !state_ff.tx2[SYNC_BIT]))
        else $error("divider not cleared");
    AST_ACK_ONE: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        state_ff.ack |=> !state_ff.ack)
        else $error("ack longer than one cycle");
endmodule

// ==== tb_serial_baud_rate_generator.sv ====
`timescale 1ns/1ns
module tb_serial_baud_rate_generator
    import sbrg_pkg::*;
;
    logic        sys_clk_in, resetn_in, avs_read_in, avs_write_in;
    logic [11:0] avs_address_in;
    logic [3:0]  avs_byteenable_in;
    logic [31:0] avs_writedata_in, avs_readdata_out;
    logic        avs_waitrequest_out;
    sbrg_rate_s  rate_port1_out, rate_port2_out;
    int          mismatches, n_compared;
    logic [31:0] rd;
    int          n;

    sbrg_top DUT (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .rate_port1_out(rate_port1_out), .rate_port2_out(rate_port2_out));

    // 250 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end
    ////////////////////////////////////////
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Hold the request until waitrequest is seen low; bounded
    task automatic wait_ack();
        int k;
        k = 0;
        do begin
            @(posedge sys_clk_in);
            k++;
        end while (avs_waitrequest_out !== 1'b0 && k < 20);
        if (avs_waitrequest_out !== 1'b0) begin
            mismatches++;
            test_done();
        end
    endtask

    // Release then let one edge pass, so strobes never toggle twice
    task automatic bus_write(input logic [11:0] a, input logic [7:0] d);
        avs_address_in   <= a;
        avs_writedata_in <= {24'h000000, d};
        avs_write_in     <= 1'b1;
        wait_ack();
        avs_write_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask

    task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
        avs_address_in <= a;
        avs_read_in    <= 1'b1;
        wait_ack();
        d = avs_readdata_out;
        avs_read_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask

    function automatic logic pulse(input int p, input bit b);
        sbrg_rate_s r;
        r = p ? rate_port2_out : rate_port1_out;
        return b ? r.bit_clk : r.tick;
    endfunction

    // Count edges to the next pulse; running out of bound is a failure
    task automatic next_pulse(input int p, input bit b, input int bnd,
                              output int cnt);
        cnt = 0;
        do begin
            @(posedge sys_clk_in);
            cnt++;
        end while (pulse(p, b) !== 1'b1 && cnt < bnd);
        if (pulse(p, b) !== 1'b1) begin
            mismatches++;
            test_done();
        end
    endtask

    task automatic do_reset();
        resetn_in <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        @(posedge sys_clk_in);
    endtask
    ////////////////////////////////////////
    task automatic reset_values();
        bus_read(12'h05C, rd); check(rd, 32'h00000000);
        bus_read(12'h45C, rd); check(rd, 32'h00000000);
        bus_read(12'h054, rd); check(rd, 32'h00000002);
        bus_read(12'h454, rd); check(rd, 32'h00000002);
        bus_read(12'h04C, rd); check(rd, 32'h00000000);
        bus_read(12'h000, rd); check(rd, 32'h00000000);
    endtask

    // Ports must not alias; a lane-0-off write must not land
    task automatic independent_regs();
        bus_write(12'h05C, 8'h12);
        bus_write(12'h45C, 8'h34);
        avs_byteenable_in <= 4'hE;
        bus_write(12'h05C, 8'hFF);
        avs_byteenable_in <= 4'hF;
        bus_read(12'h05C, rd); check(rd, 32'h00000012);
        bus_read(12'h45C, rd); check(rd, 32'h00000034);
        bus_write(12'h04C, 8'hFF);
        bus_read(12'h04C, rd); check(rd, 32'h000000F1);
        bus_read(12'h44C, rd); check(rd, 32'h00000000);
    endtask

    task automatic check_rate(input int p, input logic [7:0] x,
                              input logic s);
        int per;
        bus_write(p ? 12'h454 : 12'h054, {3'h0, s, 4'h0});
        bus_read(p ? 12'h454 : 12'h054, rd);
        check(rd, {27'h0, s, 4'h2});
        bus_write(p ? 12'h45C : 12'h05C, x);
        next_pulse(p, 0, 300, n);
        next_pulse(p, 0, 300, n);
        check(32'(n), 32'(x) + 1);
        per = (s ? 4 : 64) * (int'(x) + 1);
        next_pulse(p, 1, per + 2, n);
        next_pulse(p, 1, per + 2, n);
        check(32'(n), 32'(per));
    endtask

    // A long count in progress must not delay the new rate
    task automatic restart_on_write();
        bus_write(12'h05C, 8'hFF);
        next_pulse(0, 0, 300, n);
        repeat (50) @(posedge sys_clk_in);
        bus_write(12'h05C, 8'h03);
        next_pulse(0, 0, 8, n);
        next_pulse(0, 0, 300, n);
        check(32'(n), 32'h00000004);
    endtask

    // A cleared divider makes the timer tick every cycle
    task automatic reset_mid_run();
        bus_write(12'h45C, 8'h77);
        do_reset();
        bus_read(12'h45C, rd); check(rd, 32'h00000000);
        bus_read(12'h454, rd); check(rd, 32'h00000002);
        next_pulse(1, 0, 4, n);
        next_pulse(1, 0, 4, n);
        check(32'(n), 32'h00000001);
    endtask
    ////////////////////////////////////////
    initial begin
        mismatches = 0;
        n_compared = 0;
        resetn_in = 1'b0;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_address_in = 12'h000;
        avs_byteenable_in = 4'hF;
        avs_writedata_in = 32'h00000000;
        do_reset();
        reset_values();
        independent_regs();
        check_rate(0, 8'h00, 1'b1);
        check_rate(0, 8'h05, 1'b1);
        check_rate(0, 8'h05, 1'b0);
        check_rate(1, 8'h00, 1'b0);
        check_rate(1, 8'hFF, 1'b1);
        check_rate(1, 8'h02, 1'b0);
        restart_on_write();
        reset_mid_run();
        test_done();
    end
endmodule
